/* verilog/pin_protect_pkg.sv */
/*
  Shared constants for the flash pin protection and strap block: widths,
  address tags of the boot regions, sector numbering and reset values.
  Assumes the top module and the mux address capture refer to it by name.
*/
package pin_protect_pkg;

  // array layout
  localparam int ADDR_W = 18;
  localparam int SECTOR_NUM = 7;
  localparam int STRAP_W = 4;
  localparam int GPI_W = 5;
  localparam int ROW_W = 11;
  localparam int COL_W = 7;

  // address tags: top 16-Kbyte boot sector and uppermost 64-Kbyte region
  localparam logic [3:0] TOP16_TAG = 4'hF;
  localparam logic [1:0] TOP64_TAG = 2'h3;

  // sector numbers of the seven-sector layout
  localparam logic [2:0] SECTOR_SUB32 = 3'h3;
  localparam logic [2:0] SECTOR_SUB8_LO = 3'h4;
  localparam logic [2:0] SECTOR_SUB8_HI = 3'h5;
  localparam logic [2:0] SECTOR_TOP16 = 3'h6;

  // strap value of the boot device
  localparam logic [3:0] BOOT_STRAP_ID = 4'h0;

  // pin synchroniser: 15 pins, all low after reset (resets asserted, locks on)
  localparam int PIN_W = 15;
  localparam logic [14:0] PIN_SYNC_RESET = 15'h0000;

  // values after reset
  localparam logic [4:0] GPI_READBACK_RESET = 5'h00;
  localparam logic [17:0] MUX_ADDR_RESET = 18'h00000;
  localparam logic [10:0] ROW_RESET = 11'h000;
  localparam logic [6:0] COL_RESET = 7'h00;

endpackage : pin_protect_pkg

/* verilog/mux_addr_if.sv */
/*
  Carrier between the top module and the multiplexed address capture:
  synchronised strobe, the eleven reused pins and the assembled address.
  Assumes both ends run on the same clock.
*/
interface mux_addr_if;
  logic enable;
  logic strobe_s;
  logic [10:0] row_bits;
  logic [17:0] addr;
  logic addr_valid;

  modport capture (
    input enable,
    input strobe_s,
    input row_bits,
    output addr,
    output addr_valid
  );

  modport user (
    output enable,
    output strobe_s,
    output row_bits,
    input addr,
    input addr_valid
  );
endinterface : mux_addr_if

/* verilog/mux_addr_capture.sv */
/*
  Row/column address capture of the multiplexed programming interface.
  Assumes strobe and address pins are already synchronised to clk and that
  the programmer keeps each half steady across its strobe edge.
*/
module mux_addr_capture (
  input wire logic clk,
  input wire logic reset,
  mux_addr_if.capture m
);

  logic strobe_d_r;
  logic [10:0] row_r;
  logic [6:0] col_r;
  logic row_seen_r;
  logic valid_r;

  wire strobe_fall = m.enable & strobe_d_r & ~m.strobe_s;
  wire strobe_rise = m.enable & ~strobe_d_r & m.strobe_s;

  always_ff @(posedge clk) begin
    if (reset) begin
      strobe_d_r <= 1'b0;
      row_r <= pin_protect_pkg::ROW_RESET;
      col_r <= pin_protect_pkg::COL_RESET;
      row_seen_r <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      strobe_d_r <= m.strobe_s;
      if (strobe_fall) begin
        row_r <= m.row_bits;
        row_seen_r <= 1'b1;
        valid_r <= 1'b0;
      end
      if (strobe_rise) begin
        col_r <= m.row_bits[6:0];
        valid_r <= row_seen_r;
        row_seen_r <= 1'b0;
      end
      if (!m.enable) begin
        valid_r <= 1'b0;
        row_seen_r <= 1'b0;
      end
    end
  end

  assign m.addr = {col_r, row_r};
  assign m.addr_valid = valid_r;

endmodule : mux_addr_capture

/* verilog/flash_pin_protect_and_strap.sv */
/*
  Pin-level control of a boot flash with a bus interface and a multiplexed
  programming interface: resets, hardware write protection, identity straps,
  general-purpose input readback and pin reuse in programming mode.
  Assumes every pin input is asynchronous to clk; request, lock, cycle type
  and readback strobes come from neighbouring logic on clk.
*/
module flash_pin_protect_and_strap #(
  parameter int ADDR_W = 18,
  parameter int SECTOR_NUM = 7,
  parameter int STRAP_W = 4,
  parameter int GPI_W = 5
) (
  input wire logic clk,
  input wire logic reset,
  // pins
  input wire logic interface_reset_n,
  input wire logic cpu_init_reset_n,
  input wire logic top_sector_lock_n,
  input wire logic write_protect_n,
  input wire logic [3:0] bus_strap_id,
  input wire logic [4:0] gp_inputs,
  input wire logic interface_select,
  input wire logic row_col_strobe,
  // from command and cycle logic
  input wire logic pe_req,
  input wire logic pe_is_erase,
  input wire logic pe_erase_uniform,
  input wire logic [17:0] pe_addr,
  input wire logic [6:0] sector_lock,
  input wire logic hub_cycle,
  input wire logic cycle_id_valid,
  input wire logic [3:0] cycle_id,
  input wire logic gpi_read_start,
  input wire logic read_array_cmd,
  // status and results
  output logic device_reset,
  output logic write_block,
  output logic lad_oe_n,
  output logic read_array_mode,
  output logic mux_mode,
  output logic pe_grant,
  output logic pe_reject,
  output logic device_selected,
  output logic boot_device,
  output logic [4:0] gp_input_readback,
  output logic [17:0] mux_address,
  output logic mux_address_valid,
  output logic read_output_enable_n
);

  // pin synchroniser: stage one feeds stage two only
  logic [14:0] pin_meta_r;
  logic [14:0] pin_sync_r;

  wire [14:0] pin_raw = {row_col_strobe, interface_select, interface_reset_n,
                         cpu_init_reset_n, top_sector_lock_n, write_protect_n,
                         bus_strap_id, gp_inputs};

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_meta_r <= pin_protect_pkg::PIN_SYNC_RESET;
      pin_sync_r <= pin_protect_pkg::PIN_SYNC_RESET;
    end else begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
    end
  end

  wire [4:0] gp_s = pin_sync_r[4:0];
  wire [3:0] id_s = pin_sync_r[8:5];
  wire wp_n_s = pin_sync_r[9];
  wire tbl_n_s = pin_sync_r[10];
  wire init_n_s = pin_sync_r[11];
  wire rst_n_s = pin_sync_r[12];
  wire ic_s = pin_sync_r[13];
  wire strobe_s = pin_sync_r[14];

  // interface selection and reset
  logic mux_mode_r;
  logic device_reset_r;
  logic write_block_r;
  logic lad_oe_n_r;
  logic read_array_mode_r;

  // init is the output enable in programming mode, so it resets only in-system
  wire init_reset_w = ~mux_mode_r & ~init_n_s;
  wire in_reset_w = ~rst_n_s | init_reset_w;

  // select is only looked at while the interface reset holds, so a change
  // during operation has no effect until the next reset
  always_ff @(posedge clk) begin
    if (reset) begin
      mux_mode_r <= 1'b0;
    end else if (!rst_n_s) begin
      mux_mode_r <= ic_s;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      device_reset_r <= 1'b1;
    end else begin
      device_reset_r <= in_reset_w;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      write_block_r <= 1'b1;
    end else begin
      write_block_r <= in_reset_w;
    end
  end

  // the bus pins stay released in programming mode, whose data path lies elsewhere
  always_ff @(posedge clk) begin
    if (reset) begin
      lad_oe_n_r <= 1'b1;
    end else begin
      lad_oe_n_r <= in_reset_w | mux_mode_r;
    end
  end

  // sector decode for the seven-sector layout
  wire addr_main = pe_addr[17:16] != pin_protect_pkg::TOP64_TAG;
  wire [2:0] sector_sub = ~pe_addr[15] ? pin_protect_pkg::SECTOR_SUB32 :
                          (pe_addr[14:13] == 2'h0) ? pin_protect_pkg::SECTOR_SUB8_LO :
                          (pe_addr[14:13] == 2'h1) ? pin_protect_pkg::SECTOR_SUB8_HI :
                          pin_protect_pkg::SECTOR_TOP16;
  wire [2:0] sector_idx = addr_main ? {1'b0, pe_addr[17:16]} : sector_sub;

  wire top16_hit = pe_addr[17:14] == pin_protect_pkg::TOP16_TAG;
  wire top64_hit = pe_addr[17:16] == pin_protect_pkg::TOP64_TAG;
  wire uniform_erase = pe_is_erase & pe_erase_uniform;

  // the top boot region follows the erase variant; programs use the 16K sector
  wire top_region_hit = uniform_erase ? top64_hit : top16_hit;

  // pin protection only adds to the lock registers, which it never writes
  wire tbl_block = ~tbl_n_s & top_region_hit;
  wire wp_block = ~wp_n_s & ~top_region_hit;

  // one-hot sector selects; the erase-block select sets bits 3 to 6 together for the top 64K; a lock bit counts where its select is set
  logic [6:0] sector_sel;
  logic [6:0] block_sel;

  for (genvar s = 0; s < SECTOR_NUM; s++) begin : g_sector
    // the sub-sectors together make up the uppermost 64K erase block
    if (s < pin_protect_pkg::SECTOR_SUB32) begin : g_main
      assign block_sel[s] = pe_addr[17:16] == 2'(s);
    end else begin : g_top
      assign block_sel[s] = top64_hit;
    end
    assign sector_sel[s] = sector_idx == 3'(s);
  end

  wire sector_lock_hit = |(sector_sel & sector_lock);
  wire block_lock_hit = |(block_sel & sector_lock);
  wire reg_block = uniform_erase ? block_lock_hit : sector_lock_hit;

  wire pe_allow = ~tbl_block & ~wp_block & ~reg_block;
  wire pe_take = pe_req & ~in_reset_w;
  wire pe_grant_nxt = pe_take & pe_allow;
  wire pe_reject_nxt = pe_take & ~pe_allow;

  // reset and the read array command win over a grant in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      read_array_mode_r <= 1'b1;
    end else if (in_reset_w || read_array_cmd) begin
      read_array_mode_r <= 1'b1;
    end else if (pe_grant_nxt) begin
      read_array_mode_r <= 1'b0;
    end
  end

  logic pe_grant_r;
  logic pe_reject_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      pe_grant_r <= 1'b0;
    end else begin
      pe_grant_r <= pe_grant_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pe_reject_r <= 1'b0;
    end else begin
      pe_reject_r <= pe_reject_nxt;
    end
  end

  // identity straps
  logic device_selected_r;
  logic boot_device_r;

  wire id_match = cycle_id == id_s;
  wire select_nxt = hub_cycle ? id_match : 1'b1;

  always_ff @(posedge clk) begin
    if (reset) begin
      device_selected_r <= 1'b0;
    end else if (cycle_id_valid) begin
      device_selected_r <= select_nxt & ~mux_mode_r;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      boot_device_r <= 1'b0;
    end else begin
      boot_device_r <= hub_cycle & (id_s == pin_protect_pkg::BOOT_STRAP_ID);
    end
  end

  // general-purpose input readback, sampled once at the start of the read;
  // the system keeps the pins still until the read ends
  logic [4:0] gp_input_readback_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      gp_input_readback_r <= pin_protect_pkg::GPI_READBACK_RESET;
    end else if (gpi_read_start && !mux_mode_r && !in_reset_w) begin
      gp_input_readback_r <= gp_s;
    end
  end

  // programming mode pin reuse
  mux_addr_if mux_bus ();

  assign mux_bus.enable = mux_mode_r & rst_n_s;
  assign mux_bus.strobe_s = strobe_s;
  assign mux_bus.row_bits = {gp_s, wp_n_s, tbl_n_s, id_s};

  mux_addr_capture u_capture (
    .clk(clk),
    .reset(reset),
    .m(mux_bus.capture)
  );

  logic [17:0] mux_address_r;
  logic mux_address_valid_r;
  logic read_output_enable_n_r;

  // one more stage so every output leaves a flip-flop; costs a cycle of latency
  always_ff @(posedge clk) begin
    if (reset) begin
      mux_address_r <= pin_protect_pkg::MUX_ADDR_RESET;
    end else begin
      mux_address_r <= mux_bus.addr;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mux_address_valid_r <= 1'b0;
    end else begin
      mux_address_valid_r <= mux_bus.addr_valid;
    end
  end

  // outside programming mode the output enable stays idle whatever init does
  always_ff @(posedge clk) begin
    if (reset) begin
      read_output_enable_n_r <= 1'b1;
    end else begin
      read_output_enable_n_r <= mux_mode_r ? init_n_s : 1'b1;
    end
  end

  assign device_reset = device_reset_r;
  assign write_block = write_block_r;
  assign lad_oe_n = lad_oe_n_r;
  assign read_array_mode = read_array_mode_r;
  assign mux_mode = mux_mode_r;
  assign pe_grant = pe_grant_r;
  assign pe_reject = pe_reject_r;
  assign device_selected = device_selected_r;
  assign boot_device = boot_device_r;
  assign gp_input_readback = gp_input_readback_r;
  assign mux_address = mux_address_r;
  assign mux_address_valid = mux_address_valid_r;
  assign read_output_enable_n = read_output_enable_n_r;

endmodule : flash_pin_protect_and_strap

/* dv/flash_pin_protect_and_strap_checker.sv */
/*
  Port-level assertions for the pin protection and strap block.
  Assumes one clock and the synchronous reset of the top module.
*/
module pin_protect_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic top_sector_lock_n,
  input wire logic write_protect_n,
  input wire logic [3:0] bus_strap_id,
  input wire logic pe_req,
  input wire logic [17:0] pe_addr,
  input wire logic hub_cycle,
  input wire logic cycle_id_valid,
  input wire logic [3:0] cycle_id,
  input wire logic gpi_read_start,
  input wire logic mux_mode,
  input wire logic device_reset,
  input wire logic write_block,
  input wire logic lad_oe_n,
  input wire logic pe_grant,
  input wire logic pe_reject,
  input wire logic device_selected,
  input wire logic [4:0] gp_input_readback,
  input wire logic read_output_enable_n,
  input wire logic mux_address_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // two-cycle form: the output lags the internal reset by one edge
  chk_req_answer: assert property (pe_req && !device_reset && !mux_mode ##1 !device_reset
    |-> pe_grant || pe_reject) else $error("request got no answer");
  chk_reset_refuses: assert property (pe_req && device_reset ##1 device_reset
    |-> !pe_grant && !pe_reject) else $error("request answered in reset");
  chk_reset_blocks: assert property (device_reset |-> write_block && lad_oe_n)
    else $error("reset without write block or float");
  chk_top_lock: assert property (!top_sector_lock_n [*4] ##0 (pe_req &&
    pe_addr[17:14] == 4'hF && !device_reset && !mux_mode) ##1 !device_reset
    |-> pe_reject) else $error("top sector not guarded");
  chk_wp_guard: assert property (!write_protect_n [*4] ##0 (pe_req &&
    pe_addr[17:16] != 2'h3 && !device_reset && !mux_mode) ##1 !device_reset
    |-> pe_reject) else $error("lower sectors not guarded");
  chk_one_answer: assert property (!(pe_grant && pe_reject))
    else $error("grant and reject together");
  chk_strap_match: assert property ($stable(bus_strap_id) [*4] ##0 (cycle_id_valid &&
    hub_cycle && !mux_mode && !device_reset) ##1 !device_reset
    |-> device_selected == ($past(cycle_id) == $past(bus_strap_id)))
    else $error("strap select wrong");
  chk_lpc_select: assert property (cycle_id_valid && !hub_cycle && !mux_mode &&
    !device_reset ##1 !device_reset |-> device_selected) else $error("pin count not selected");
  chk_gpi_hold: assert property (!gpi_read_start |=> $stable(gp_input_readback))
    else $error("readback changed without read");
  chk_oe_bus_idle: assert property (!mux_mode ##1 !mux_mode |-> read_output_enable_n)
    else $error("output enable active in bus mode");
  cov_grant: cover property (pe_grant);
  cov_reject: cover property (pe_reject);
  cov_mux_addr: cover property ($rose(mux_address_valid));
  cov_hub_sel: cover property (hub_cycle && device_selected);
endmodule : pin_protect_checker

bind flash_pin_protect_and_strap pin_protect_checker chk_i (.*);

/* dv/prog_model.sv */
/*
  Manufacturing programmer model: presents row then column on the eleven
  reused pins around the strobe edges. Assumes a go pulse per address.
*/
module prog_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [17:0] addr,
  output logic row_col_strobe,
  output logic [10:0] pa
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    row_col_strobe = 1'b1;
    pa = 11'h7FF;
  end
  // four cycles of hold each side, more than the three the capture needs
  always @(posedge clk) begin
    if (go) begin
      #1 pa = addr[10:0];
      repeat (4) @(posedge clk);
      #1 row_col_strobe = 1'b0;
      repeat (4) @(posedge clk);
      #1 pa = {4'h0, addr[17:11]};
      repeat (4) @(posedge clk);
      #1 row_col_strobe = 1'b1;
      repeat (4) @(posedge clk);
      #1 pa = ~pa;
    end
  end
endmodule : prog_model

/* dv/tb_top.sv */
/*
  Self-checking bench for the pin protection and strap block.
  Assumes the design's ports; the programmer model owns the strobe.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset = 1, interface_reset_n = 0, cpu_init_reset_n = 0;
  logic top_sector_lock_n = 0, write_protect_n = 0, interface_select = 0;
  logic [3:0] bus_strap_id = 0, cycle_id = 0;
  logic [4:0] gp_inputs = 0;
  logic pe_req = 0, pe_is_erase = 0, pe_erase_uniform = 0, hub_cycle = 0;
  logic cycle_id_valid = 0, gpi_read_start = 0, read_array_cmd = 0, go = 0, mo = 0;
  logic [17:0] pe_addr = 0, ga = 0;
  logic [6:0] sector_lock = 0;
  wire [10:0] pa;
  wire row_col_strobe;
  logic device_reset, write_block, lad_oe_n, read_array_mode, mux_mode, pe_grant;
  logic pe_reject, device_selected, boot_device, mux_address_valid, read_output_enable_n;
  logic [4:0] gp_input_readback;
  logic [17:0] mux_address;
  int fail_count = 0, n_tests = 0;
  flash_pin_protect_and_strap uut (.*);
  prog_model pm (.clk(clk), .go(go), .addr(ga), .row_col_strobe(row_col_strobe), .pa(pa));
  always #50 clk = ~clk;
  always @(pa) if (mo) {gp_inputs, write_protect_n, top_sector_lock_n, bus_strap_id} = pa;
  task end_sim;
    $display("checks %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task chk(input string n, input logic [17:0] e, input logic [17:0] s);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task req(input logic er, un, input logic [17:0] a, input logic g, r);
    pe_is_erase = er;
    pe_erase_uniform = un;
    pe_addr = a;
    pe_req = 1;
    cyc(1);
    pe_req = 0;
    chk("grant", g, pe_grant);
    chk("reject", r, pe_reject);
    cyc(1);
  endtask : req
  task sel(input logic [3:0] i, input logic e);
    cycle_id = i;
    cycle_id_valid = 1;
    cyc(1);
    cycle_id_valid = 0;
    chk("selected", e, device_selected);
    cyc(1);
  endtask : sel
  initial begin
    #200000;
    fail_count++;
    end_sim();
  end
  initial begin
    cyc(4);
    reset = 0;
    cyc(1);
    chk("lad_oe_n", 1, lad_oe_n);
    req(0, 0, 18'h00000, 0, 0);
    interface_reset_n = 1;
    cyc(4);
    chk("init reset", 1, device_reset);
    cpu_init_reset_n = 1;
    cyc(4);
    chk("reset", 0, device_reset);
    chk("lad_oe_n", 0, lad_oe_n);
    chk("read array", 1, read_array_mode);
    req(0, 0, 18'h3C000, 0, 1);
    req(1, 1, 18'h30000, 0, 1);
    write_protect_n = 1;
    cyc(4);
    req(1, 0, 18'h30000, 1, 0);
    chk("read array", 0, read_array_mode);
    read_array_cmd = 1;
    cyc(1);
    read_array_cmd = 0;
    cyc(1);
    chk("read array", 1, read_array_mode);
    top_sector_lock_n = 1;
    write_protect_n = 0;
    cyc(4);
    req(0, 0, 18'h3C000, 1, 0);
    req(0, 0, 18'h00000, 0, 1);
    req(1, 1, 18'h30000, 1, 0);
    write_protect_n = 1;
    sector_lock = 7'h40;
    cyc(4);
    req(0, 0, 18'h3C000, 0, 1);
    req(1, 1, 18'h30000, 0, 1);
    sector_lock = 7'h02;
    req(0, 0, 18'h10000, 0, 1);
    req(0, 0, 18'h20000, 1, 0);
    cpu_init_reset_n = 0;
    cyc(4);
    chk("write block", 1, write_block);
    req(0, 0, 18'h20000, 0, 0);
    cpu_init_reset_n = 1;
    bus_strap_id = 4'h5;
    hub_cycle = 1;
    cyc(4);
    for (int i = 4; i < 7; i++) sel(i[3:0], i == 5);
    chk("boot", 0, boot_device);
    hub_cycle = 0;
    sel(4'h4, 1);
    bus_strap_id = 4'h0;
    hub_cycle = 1;
    cyc(4);
    chk("boot", 1, boot_device);
    gp_inputs = 5'h15;
    cyc(3);
    gpi_read_start = 1;
    cyc(1);
    gpi_read_start = 0;
    chk("gpi", 5'h15, gp_input_readback);
    gp_inputs = 5'h0A;
    cyc(4);
    chk("gpi held", 5'h15, gp_input_readback);
    interface_select = 1;
    interface_reset_n = 0;
    cyc(4);
    interface_reset_n = 1;
    mo = 1;
    cyc(4);
    chk("mux mode", 1, mux_mode);
    ga = 18'h2A5C3;
    go = 1;
    cyc(1);
    go = 0;
    for (int k = 0; k < 40 && mux_address_valid !== 1'b1; k++) cyc(1);
    chk("mux addr", 18'h2A5C3, mux_address);
    chk("mux valid", 1, mux_address_valid);
    cpu_init_reset_n = 0;
    interface_select = 0;
    cyc(4);
    chk("oe", 0, read_output_enable_n);
    chk("no reset", 0, device_reset);
    chk("mux kept", 1, mux_mode);
    end_sim();
  end
endmodule : tb_top
